// File: bench/fbc_coef_bank_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// bus and coefficient checker
// ----------------------------------------
module fbc_coef_bank_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [fbc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [fbc_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [fbc_pkg::SIDE_COUNT-1:0][fbc_pkg::SIDE_W-1:0] chan_b_side_coef,
    input wire logic [fbc_pkg::CENTER_W-1:0] chan_b_center_coef
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [fbc_pkg::IDX_W-1:0] rd_idx;
    logic rd_side;
    // index of the read in flight, kept for the answer cycle
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rd_idx <= s_axi_araddr[fbc_pkg::ADDR_W-1:2];
        end
    end
    // side taps are every tap but the centre
    always_comb begin
        rd_side = 1'b0;
        for (int i = 0; i < fbc_pkg::TAP_COUNT; i++) begin
            if (i != fbc_pkg::CENTER_TAP && rd_idx == fbc_pkg::TAP_IDX[i]) begin
                rd_side = 1'b1;
            end
        end
    end
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_done;
        $rose(s_axi_bvalid) && s_axi_bresp == fbc_pkg::RESP_OKAY;
    endsequence
    // both halves are held one cycle before the commit raises bvalid
    a_wr_answer: assert property (
        s_wr_take |-> ##2 s_axi_bvalid) else $error("write not answered");
    a_coef_only_write: assert property (
        $changed(chan_b_center_coef) || $changed(chan_b_side_coef) |-> s_wr_done)
        else $error("coefficient moved without a write");
    a_reset_clear: assert property (
        $rose(aresetn) |-> chan_b_center_coef == '0 && chan_b_side_coef == '0)
        else $error("coefficients not cleared");
    a_side_msb_zero: assert property (
        s_axi_rvalid && rd_side |-> s_axi_rdata[11] == 1'b0 && s_axi_rdata[31:16] == 16'h0000)
        else $error("side readback wrong");
    a_center_msb_zero: assert property (
        s_axi_rvalid && rd_idx == fbc_pkg::IDX_TAP5 |-> !s_axi_rdata[17] && !s_axi_rdata[31:24])
        else $error("centre readback wrong");
    a_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
    a_rd_stands: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_wr_stands: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_busy_refuse: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("accepts while busy");
endmodule
bind fbc_coef_bank fbc_coef_bank_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .chan_b_side_coef, .chan_b_center_coef);
`default_nettype wire

// File: bench/fbc_coef_bank_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module fbc_coef_bank_test;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, chan_b_coef_active;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, eb;
    logic [7:0][11:0] chan_b_side_coef;
    logic [17:0] chan_b_center_coef;
    logic [23:0] mdl [9];
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    logic [33:0] er;
    int checks, err_total;
    fbc_coef_bank dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .chan_b_side_coef, .chan_b_center_coef, .chan_b_coef_active);
    // 50 MHz clock
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // ----------------------------------------
    // bus tasks; ready on the answer side is raised at random to stall
    // ----------------------------------------
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] r);
        @(posedge aclk);
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if ($urandom_range(1, 0)) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1));
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        rq.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if ($urandom_range(1, 0)) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
        s_axi_rready <= 1'b0;
    endtask
    // tap write with byte strobes; side taps keep two bytes only
    task automatic put(input int t, input logic [31:0] d, input logic [3:0] s);
        wr({fbc_pkg::TAP_IDX[t], 2'b00}, d, s, fbc_pkg::RESP_OKAY);
        for (int b = 0; b < (t == 4 ? 3 : 2); b++) begin
            if (s[b]) mdl[t][8*b+:8] = d[8*b+:8];
        end
    endtask
    // readback hides the coefficient sign bit
    task automatic get(input int t);
        rd({fbc_pkg::TAP_IDX[t], 2'b00}, {8'h00, mdl[t] & (t == 4 ? 24'hfdffff : 24'h00f7ff)},
            fbc_pkg::RESP_OKAY);
    endtask
    task automatic chk_out();
        for (int t = 0; t < 9; t++) begin
            if (t == 4) `CHK(chan_b_center_coef, mdl[4][17:0])
            else `CHK(chan_b_side_coef[t < 4 ? t : t - 1], mdl[t][11:0])
        end
    endtask
    // answers are matched against the oldest note
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            eb = bq.pop_front();
            `CHK(s_axi_bresp, eb)
        end
        if (s_axi_rvalid && s_axi_rready) begin
            er = rq.pop_front();
            `CHK({s_axi_rresp, s_axi_rdata}, er)
        end
    end
    task automatic print_verdict();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // hang guard, far beyond the few hundred bus cycles used
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        print_verdict();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [8:0] nz;
        void'($urandom(16313));
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        aresetn = 1'b0;
        for (int t = 0; t < 9; t++) mdl[t] = 24'h000000;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk_out();
        for (int t = 0; t < 9; t++) get(t);
        // sign bits forced on every pass; full strobes on first pass, random strobes afterwards
        for (int n = 0; n < 3; n++) begin
            for (int t = 0; t < 9; t++) begin
                put(t, $urandom | 32'h0002_0800, n == 0 ? 4'hf : 4'($urandom));
                chk_out();
                get(t);
            end
        end
        wr(16'h1144, $urandom, 4'hf, fbc_pkg::RESP_SLVERR);
        rd(16'h1144, 32'h0, fbc_pkg::RESP_SLVERR);
        chk_out();
        wr(16'h1180, 32'h1, 4'hf, fbc_pkg::RESP_OKAY);
        `CHK(chan_b_coef_active, 1'b1)
        for (int t = 0; t < 9; t++) nz[t] = |mdl[t];
        wr(16'h1184, 32'hffffffff, 4'hf, fbc_pkg::RESP_OKAY);
        rd(16'h1184, {15'h0, 1'b1, 7'h0, nz}, fbc_pkg::RESP_OKAY);
        wr(16'h1180, 32'h0, 4'hf, fbc_pkg::RESP_OKAY);
        `CHK(chan_b_coef_active, 1'b0)
        // second reset in mid-run clears every tap
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int t = 0; t < 9; t++) mdl[t] = 24'h000000;
        @(posedge aclk);
        chk_out();
        get(4);
        repeat (2) @(posedge aclk);
        print_verdict();
    end
endmodule
`default_nettype wire

// File: core/fbc_coef_bank.sv
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - side taps hold a signed 12-bit coefficient in bits 11:0; bits 15:12 reserved, reset 0
// - centre tap holds a signed 18-bit coefficient in bits 17:0; bits 23:18 reserved
// - readback of every coefficient register returns its coefficient MSB as zero
// - register at 0x44E feeds tap four of channel b in dual mode
// - register at 0x450 feeds tap five, the centre tap, in dual mode
// - registers at 0x453 and 0x455 feed taps six and seven in dual mode
// - register at 0x457 feeds tap eight; every coefficient field resets to zero
// - taps one to three sit at 0x448, 0x44A and 0x44C as 12-bit signed
// - tap nine sits at 0x459 with the side-tap layout
module fbc_coef_bank (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [fbc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [fbc_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [fbc_pkg::STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [fbc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [fbc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [fbc_pkg::SIDE_COUNT-1:0][fbc_pkg::SIDE_W-1:0] chan_b_side_coef,
    output logic [fbc_pkg::CENTER_W-1:0] chan_b_center_coef,
    output logic chan_b_coef_active
);

    // ---------------------------------------------------------------
    // state of the bus slave
    // ---------------------------------------------------------------
    typedef struct packed {
        logic aw_held;
        logic [fbc_pkg::IDX_W-1:0] aw_idx;
        logic w_held;
        logic [fbc_pkg::DATA_W-1:0] w_data;
        logic [fbc_pkg::STRB_W-1:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [fbc_pkg::DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic dual_en;
    } fbc_slave_state_t;

    fbc_slave_state_t st;
    fbc_slave_state_t next_st;

    fbc_coef_if cif ();

    logic aw_take;
    logic w_take;
    logic ar_take;
    logic wr_fire;
    logic [fbc_pkg::TAP_SEL_W:0] wr_look;
    logic [fbc_pkg::TAP_SEL_W:0] rd_look;
    logic [fbc_pkg::IDX_W-1:0] ar_idx;
    logic [fbc_pkg::DATA_W-1:0] rd_word;
    logic [1:0] rd_resp;
    logic [fbc_pkg::DATA_W-1:0] status_word;

    // ---------------------------------------------------------------
    // address decode helpers
    // ---------------------------------------------------------------

    // map a register index to {hit, tap number 0..8}
    function automatic logic [fbc_pkg::TAP_SEL_W:0] tap_lookup(
        input logic [fbc_pkg::IDX_W-1:0] idx
    );
        logic [fbc_pkg::TAP_SEL_W:0] res;
        res = '0;
        for (int t = 0; t < fbc_pkg::TAP_COUNT; t++) begin
            if (idx == fbc_pkg::TAP_IDX[t]) begin
                res = {1'b1, fbc_pkg::TAP_SEL_W'(t)};
            end
        end
        return res;
    endfunction

    // ---------------------------------------------------------------
    // tap register store
    // ---------------------------------------------------------------
    fbc_tap_store u_store (
        .aclk(aclk),
        .aresetn(aresetn),
        .cif(cif)
    );

    // ---------------------------------------------------------------
    // handshake terms
    // ---------------------------------------------------------------

    // one write in flight: a held half blocks its channel until bvalid drains
    assign s_axi_awready = !st.aw_held && !st.bvalid;
    assign s_axi_wready = !st.w_held && !st.bvalid;
    assign s_axi_arready = !st.rvalid;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign wr_fire = st.aw_held && st.w_held && !st.bvalid;

    // ---------------------------------------------------------------
    // decode of the pending write and the arriving read
    // ---------------------------------------------------------------
    assign ar_idx = s_axi_araddr[fbc_pkg::ADDR_W-1:2];
    assign wr_look = tap_lookup(st.aw_idx);
    assign rd_look = tap_lookup(ar_idx);

    // status shows the live coefficients, not software's last write
    always_comb begin
        status_word = '0;
        status_word[fbc_pkg::TAP_COUNT-1:0] = cif.tap_nonzero;
        status_word[fbc_pkg::STATUS_DUAL_BIT] = st.dual_en;
    end

    // read mux; unmapped indices answer slverr with zero data
    always_comb begin
        rd_word = '0;
        rd_resp = fbc_pkg::RESP_OKAY;
        if (rd_look[fbc_pkg::TAP_SEL_W]) begin
            rd_word[fbc_pkg::CENTER_REG_W-1:0] = cif.rd_data;
        end else if (ar_idx == fbc_pkg::IDX_MODE_CTRL) begin
            rd_word[fbc_pkg::MODE_DUAL_BIT] = st.dual_en;
        end else if (ar_idx == fbc_pkg::IDX_STATUS) begin
            rd_word = status_word;
        end else begin
            rd_resp = fbc_pkg::RESP_SLVERR;
        end
    end

    // ---------------------------------------------------------------
    // store port drive
    // ---------------------------------------------------------------
    always_comb begin
        cif.wr_en = wr_fire && wr_look[fbc_pkg::TAP_SEL_W];
        cif.wr_tap = wr_look[fbc_pkg::TAP_SEL_W-1:0];
        cif.wr_data = st.w_data[fbc_pkg::CENTER_REG_W-1:0];
        cif.wr_strb = st.w_strb[fbc_pkg::REG_BYTES-1:0];
        cif.rd_tap = rd_look[fbc_pkg::TAP_SEL_W-1:0];
    end

    // ---------------------------------------------------------------
    // next state of the slave
    // ---------------------------------------------------------------
    always_comb begin
        next_st = st;

        // capture each write half on its own; order between them is free
        if (aw_take) begin
            next_st.aw_held = 1'b1;
            next_st.aw_idx = s_axi_awaddr[fbc_pkg::ADDR_W-1:2];
        end
        if (w_take) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end

        // both halves held: commit and raise the response together
        if (wr_fire) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = fbc_pkg::RESP_OKAY;
            if (wr_look[fbc_pkg::TAP_SEL_W]) begin
                next_st.bresp = fbc_pkg::RESP_OKAY;
            end else if (st.aw_idx == fbc_pkg::IDX_MODE_CTRL) begin
                if (st.w_strb[0]) begin
                    next_st.dual_en = st.w_data[fbc_pkg::MODE_DUAL_BIT];
                end
            end else if (st.aw_idx == fbc_pkg::IDX_STATUS) begin
                // read-only word; the write is dropped quietly
                next_st.bresp = fbc_pkg::RESP_OKAY;
            end else begin
                next_st.bresp = fbc_pkg::RESP_SLVERR;
            end
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // read answer registered one edge after the address is taken
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (ar_take) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = rd_word;
            next_st.rresp = rd_resp;
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.dual_en <= fbc_pkg::MODE_DUAL_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------

    // response channels straight from flops
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;

    // coefficients always presented; active marks dual-channel use
    assign chan_b_side_coef = cif.side_coef;
    assign chan_b_center_coef = cif.center_coef;
    assign chan_b_coef_active = st.dual_en;

endmodule
`default_nettype wire

// File: core/fbc_tap_store.sv
`timescale 1ns/10ps
`default_nettype none
// nine coefficient registers of the channel b equalizer
module fbc_tap_store (
    input wire logic aclk,
    input wire logic aresetn,
    fbc_coef_if.store cif
);

    typedef struct packed {
        logic [fbc_pkg::TAP_COUNT-1:0][fbc_pkg::CENTER_REG_W-1:0] tap;
    } fbc_store_state_t;

    fbc_store_state_t st;
    fbc_store_state_t next_st;
    logic [fbc_pkg::CENTER_REG_W-1:0] rd_word;

    // ---------------------------------------------------------------
    // byte-enabled write, width trimmed per tap
    // ---------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (cif.wr_en) begin
            for (int b = 0; b < fbc_pkg::REG_BYTES; b++) begin
                if (cif.wr_strb[b]) begin
                    next_st.tap[cif.wr_tap][b*8 +: 8] = cif.wr_data[b*8 +: 8];
                end
            end
            // side taps own only 16 bits; upper byte never exists
            if (cif.wr_tap != fbc_pkg::TAP_SEL_W'(fbc_pkg::CENTER_TAP)) begin
                next_st.tap[cif.wr_tap][fbc_pkg::CENTER_REG_W-1:fbc_pkg::SIDE_REG_W] =
                    '0;
            end
        end
    end

    // every field, reserved bits too, clears on reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= {fbc_pkg::TAP_COUNT{fbc_pkg::COEF_RESET}};
        end else begin
            st <= next_st;
        end
    end

    // ---------------------------------------------------------------
    // parallel coefficient fan-out to the filter datapath
    // ---------------------------------------------------------------
    for (genvar t = 0; t < fbc_pkg::TAP_COUNT; t++) begin : g_tap
        if (t == fbc_pkg::CENTER_TAP) begin : g_center
            assign cif.center_coef = st.tap[t][fbc_pkg::CENTER_W-1:0];
        end else if (t < fbc_pkg::CENTER_TAP) begin : g_lo
            assign cif.side_coef[t] = st.tap[t][fbc_pkg::SIDE_W-1:0];
        end else begin : g_hi
            assign cif.side_coef[t-1] = st.tap[t][fbc_pkg::SIDE_W-1:0];
        end
        assign cif.tap_nonzero[t] = |st.tap[t];
    end

    // ---------------------------------------------------------------
    // readback; the coefficient sign bit always reads as zero
    // ---------------------------------------------------------------
    always_comb begin
        rd_word = fbc_pkg::COEF_RESET;
        if (cif.rd_tap < fbc_pkg::TAP_SEL_W'(fbc_pkg::TAP_COUNT)) begin
            rd_word = st.tap[cif.rd_tap];
            if (cif.rd_tap == fbc_pkg::TAP_SEL_W'(fbc_pkg::CENTER_TAP)) begin
                rd_word[fbc_pkg::CENTER_MSB] = 1'b0;
            end else begin
                rd_word[fbc_pkg::SIDE_MSB] = 1'b0;
            end
        end
    end
    assign cif.rd_data = rd_word;

endmodule
`default_nettype wire

// File: pkg/fbc_coef_if.sv
`timescale 1ns/10ps
`default_nettype none
// coefficient write/read port between the bus slave and the tap store
interface fbc_coef_if;
    logic wr_en;
    logic [fbc_pkg::TAP_SEL_W-1:0] wr_tap;
    logic [fbc_pkg::CENTER_REG_W-1:0] wr_data;
    logic [fbc_pkg::REG_BYTES-1:0] wr_strb;
    logic [fbc_pkg::TAP_SEL_W-1:0] rd_tap;
    logic [fbc_pkg::CENTER_REG_W-1:0] rd_data;
    logic [fbc_pkg::SIDE_COUNT-1:0][fbc_pkg::SIDE_W-1:0] side_coef;
    logic [fbc_pkg::CENTER_W-1:0] center_coef;
    logic [fbc_pkg::TAP_COUNT-1:0] tap_nonzero;

    modport ctrl (
        output wr_en, wr_tap, wr_data, wr_strb, rd_tap,
        input rd_data, side_coef, center_coef, tap_nonzero
    );
    modport store (
        input wr_en, wr_tap, wr_data, wr_strb, rd_tap,
        output rd_data, side_coef, center_coef, tap_nonzero
    );
endinterface
`default_nettype wire

// File: pkg/fbc_pkg.sv
// ---------------------------------------------------------------
// coefficient bank constants for the channel b equalizer
// ---------------------------------------------------------------
package fbc_pkg;

    // ---------------------------------------------------------------
    // bus geometry
    // ---------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;
    localparam int IDX_W = 14;
    localparam int ADDR_W = IDX_W + 2;
    localparam int TAP_SEL_W = 4;

    // ---------------------------------------------------------------
    // coefficient layout
    // ---------------------------------------------------------------
    localparam int TAP_COUNT = 9;
    localparam int SIDE_COUNT = TAP_COUNT - 1;
    localparam int CENTER_TAP = 4;
    localparam int SIDE_W = 12;
    localparam int CENTER_W = 18;
    localparam int SIDE_REG_W = 16;
    localparam int CENTER_REG_W = 24;
    localparam int REG_BYTES = CENTER_REG_W / 8;
    localparam int SIDE_MSB = SIDE_W - 1;
    localparam int CENTER_MSB = CENTER_W - 1;
    localparam logic [CENTER_REG_W-1:0] COEF_RESET = 24'h000000;

    // ---------------------------------------------------------------
    // register indices; byte address is four times the index
    // ---------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_TAP1 = 14'h0448;
    localparam logic [IDX_W-1:0] IDX_TAP2 = 14'h044a;
    localparam logic [IDX_W-1:0] IDX_TAP3 = 14'h044c;
    localparam logic [IDX_W-1:0] IDX_TAP4 = 14'h044e;
    localparam logic [IDX_W-1:0] IDX_TAP5 = 14'h0450;
    localparam logic [IDX_W-1:0] IDX_TAP6 = 14'h0453;
    localparam logic [IDX_W-1:0] IDX_TAP7 = 14'h0455;
    localparam logic [IDX_W-1:0] IDX_TAP8 = 14'h0457;
    localparam logic [IDX_W-1:0] IDX_TAP9 = 14'h0459;
    localparam logic [TAP_COUNT-1:0][IDX_W-1:0] TAP_IDX = {
        IDX_TAP9, IDX_TAP8, IDX_TAP7, IDX_TAP6, IDX_TAP5,
        IDX_TAP4, IDX_TAP3, IDX_TAP2, IDX_TAP1};
    localparam logic [IDX_W-1:0] IDX_MODE_CTRL = 14'h0460;
    localparam logic [IDX_W-1:0] IDX_STATUS = 14'h0461;

    // ---------------------------------------------------------------
    // control and status fields
    // ---------------------------------------------------------------
    localparam int MODE_DUAL_BIT = 0;
    localparam int STATUS_DUAL_BIT = 16;
    localparam logic MODE_DUAL_RESET = 1'b0;

    // ---------------------------------------------------------------
    // axi responses
    // ---------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
